// ==== bench/timestamp_modulo_scheduler_bench.sv ====
// Bench: register sequences and trigger timing checks.
// Assumes tms_scheduler and tms_host compiled before.
`timescale 1ns/1ns
module timestamp_modulo_scheduler_bench;
	logic clk, srst, acq_trigger, irq, pready, pslverr, e;
	logic [31:0] prdata, v;
	tms_pkg::tms_apb_req_t apb_req;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	int t_prev = 0, t_last = 0, n_trig = 0, tz;

	tms_scheduler u_dut (.clk(clk), .srst(srst), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.acq_trigger(acq_trigger), .irq(irq));
	tms_host u_host (.clk(clk), .apb_req(apb_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// Trigger timestamps in clock cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (acq_trigger === 1'b1) begin
			t_prev <= t_last;
			t_last <= cyc;
			n_trig <= n_trig + 1;
		end
	end

	// ==========================================================
	// Tasks
	task automatic conclude;
		if (u_host.hang) n_mismatch++;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic chk_in(input int x, input int lo, input int hi);
		chk({31'h0, (x >= lo && x <= hi)}, 32'h1);
	endtask : chk_in

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, v, e);
		if (u_host.hang) conclude();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, v, e);
		if (u_host.hang) conclude();
	endtask : rd

	// Bounded, so a silent scheduler ends the run
	task automatic wait_trig(input int k);
		int goal, n;
		goal = n_trig + k;
		n = 0;
		while (n_trig < goal && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n_trig < goal) begin
			n_mismatch++;
			$display("Error at %0t: trigger missing", $time);
			conclude();
		end
	endtask : wait_trig

	// ==========================================================
	// Sequence
	initial begin
		srst = 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		rd(tms_pkg::OFF_CTRL);
		chk(v, 32'h0);
		rd(tms_pkg::OFF_PERIOD);
		chk(v, 32'h0);
		rd(tms_pkg::OFF_STATE);
		chk(v, 32'h0);
		rd(8'h30);
		chk({31'h0, e}, 32'h1);
		wr(tms_pkg::OFF_PERIOD, 32'hA);
		// Start on a boundary; the first event is the boundary after it
		wr(tms_pkg::OFF_START_LO, 32'h14);
		wr(tms_pkg::OFF_MASK, 32'h3);
		wr(tms_pkg::OFF_CMD, 32'h1);
		wr(tms_pkg::OFF_CTRL, 32'h2);
		wait_trig(1);
		rd(tms_pkg::OFF_FIRST_LO);
		chk(v, 32'h1E);
		rd(tms_pkg::OFF_FIRST_HI);
		chk(v, 32'h0);
		rd(tms_pkg::OFF_STATE);
		chk(v, 32'h2);
		rd(tms_pkg::OFF_STATUS);
		chk(v, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wait_trig(1);
		chk(t_last - t_prev, 200);
		wr(tms_pkg::OFF_STATUS, 32'h3);
		rd(tms_pkg::OFF_STATUS);
		chk(v, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(tms_pkg::OFF_MASK, 32'h0);
		wait_trig(1);
		chk(t_last - t_prev, 200);
		rd(tms_pkg::OFF_STATUS);
		chk(v, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(tms_pkg::OFF_PERIOD, 32'h14);
		wait_trig(1);
		chk(t_last - t_prev, 400);
		wr(tms_pkg::OFF_CMD, 32'h1);
		tz = cyc;
		wr(tms_pkg::OFF_CMD, 32'h2);
		rd(tms_pkg::OFF_READ_LO);
		chk(v, 32'h0);
		rd(tms_pkg::OFF_READ_HI);
		chk(v, 32'h0);
		wait_trig(1);
		chk_in(t_last - tz, 380, 420);
		wr(tms_pkg::OFF_CTRL, 32'h0);
		wr(tms_pkg::OFF_PERIOD, 32'hA);
		wr(tms_pkg::OFF_CMD, 32'h1);
		wr(tms_pkg::OFF_CTRL, 32'h2);
		repeat (490) @(posedge clk);
		wr(tms_pkg::OFF_CMD, 32'h1);
		tz = cyc;
		wait_trig(1);
		chk_in(t_last - tz, 580, 620);
		rd(tms_pkg::OFF_FIRST_LO);
		chk(v, 32'h1E);
		// Precision counter is not cleared by the zero command in PTP mode
		wr(tms_pkg::OFF_CTRL, 32'h1);
		wr(tms_pkg::OFF_CMD, 32'h1);
		wr(tms_pkg::OFF_CMD, 32'h2);
		rd(tms_pkg::OFF_READ_LO);
		chk({31'h0, v > 32'h100}, 32'h1);
		wr(tms_pkg::OFF_PERIOD, 32'h3E8);
		wr(tms_pkg::OFF_START_LO, 32'h0);
		wr(tms_pkg::OFF_CTRL, 32'h3);
		wait_trig(2);
		chk_in(t_last - t_prev, 159, 161);
		conclude();
	end
endmodule : timestamp_modulo_scheduler_bench

// ==== bench/tms_host.sv ====
// APB host model that configures the scheduler for the bench.
// Assumes one clock; the slave may add wait states.
`timescale 1ns/1ns
module tms_host (
	input wire logic clk,
	output tms_pkg::tms_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ==========================================================
	// Transfers
	logic hang;

	initial begin
		apb_req = '0;
		hang = 1'b0;
	end

	// Request held until pready, for up to 16 cycles, so slow slaves are served too
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		if (n >= 16) hang = 1'b1;
		apb_req <= '0;
	endtask : xfer
endmodule : tms_host

// ==== design/tms_pkg.sv ====
// Constants and carrier types of the timestamp modulo scheduler.
// Assumes a 20 MHz device clock and an APB master with 32-bit data.
package tms_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOCAL_TICK_US = 1;
	localparam int LOCAL_TICK_NS = LOCAL_TICK_US * 1000;
	localparam int PTP_TICK_NS = 8;
	localparam int US_CYCLES = (LOCAL_TICK_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
	localparam logic [6:0] CLK_NS_W = 7'(CLK_PERIOD_NS);
	localparam logic [6:0] PTP_NS_W = 7'(PTP_TICK_NS);

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_START_LO = 8'h08;
	localparam logic [7:0] OFF_START_HI = 8'h0C;
	localparam logic [7:0] OFF_PERIOD = 8'h10;
	localparam logic [7:0] OFF_FIRST_LO = 8'h14;
	localparam logic [7:0] OFF_FIRST_HI = 8'h18;
	localparam logic [7:0] OFF_READ_LO = 8'h1C;
	localparam logic [7:0] OFF_READ_HI = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_MASK = 8'h28;
	localparam logic [7:0] OFF_STATE = 8'h2C;

	// ==========================================================
	// Field positions and reset values
	localparam int CTRL_PTP_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CMD_ZERO_BIT = 0;
	localparam int CMD_CAPTURE_BIT = 1;
	localparam int STAT_EVENT_BIT = 0;
	localparam int STAT_FIRST_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
	localparam logic [63:0] TIME_RST = 64'h0000_0000_0000_0000;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SCH_IDLE = 2'b00,
		SCH_PENDING = 2'b01,
		SCH_RUNNING = 2'b10
	} tms_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tms_apb_req_t;

endpackage : tms_pkg

// ==== design/tms_scheduler.sv ====
// Timestamp modulo scheduler: counters, modulo phase, APB registers.
// Assumes an APB master on clk; no other clock enters the block.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module tms_scheduler (
	input wire logic clk,
	input wire logic srst,
	input wire tms_pkg::tms_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic acq_trigger,
	output logic irq
);

	// ==========================================================
	// Declarations
	logic [1:0] ctrl_q;
	logic [63:0] start_q;
	logic [31:0] period_q;
	logic [63:0] first_q;
	logic [63:0] readback_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [4:0] div_q;
	logic [63:0] local_q;
	logic [63:0] ptp_q;
	logic [2:0] rem_q;
	logic [31:0] phase_q;
	logic [31:0] prdata_q;
	logic slverr_q;
	logic trig_q;
	tms_pkg::tms_state_t state_q;

	logic setup;
	logic wr_en;
	logic hit;
	logic zero_cmd;
	logic capture_cmd;
	logic ptp_sel;
	logic run;
	logic us_tick;
	logic [6:0] ns_sum;
	logic [3:0] ptp_step;
	logic [63:0] local_next;
	logic [63:0] ptp_next;
	logic [63:0] sel_next;
	logic [31:0] sel_step;
	logic [32:0] phase_sum;
	logic boundary;
	logic phase_clr;
	logic ev;
	logic first_ev;
	logic [31:0] rd_mux;

	// ==========================================================
	// APB decode
	assign setup = apb_req.psel && !apb_req.penable;
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign pready = apb_req.psel && apb_req.penable;
	assign pslverr = slverr_q;
	assign prdata = prdata_q;
	assign zero_cmd = wr_en && apb_req.paddr == tms_pkg::OFF_CMD &&
		apb_req.pwdata[tms_pkg::CMD_ZERO_BIT];
	assign capture_cmd = wr_en && apb_req.paddr == tms_pkg::OFF_CMD &&
		apb_req.pwdata[tms_pkg::CMD_CAPTURE_BIT];
	assign ptp_sel = ctrl_q[tms_pkg::CTRL_PTP_BIT];
	assign run = ctrl_q[tms_pkg::CTRL_RUN_BIT];

	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (apb_req.paddr)
			tms_pkg::OFF_CTRL: rd_mux = {30'h0, ctrl_q};
			tms_pkg::OFF_CMD: rd_mux = 32'h0000_0000;
			tms_pkg::OFF_START_LO: rd_mux = start_q[31:0];
			tms_pkg::OFF_START_HI: rd_mux = start_q[63:32];
			tms_pkg::OFF_PERIOD: rd_mux = period_q;
			tms_pkg::OFF_FIRST_LO: rd_mux = first_q[31:0];
			tms_pkg::OFF_FIRST_HI: rd_mux = first_q[63:32];
			tms_pkg::OFF_READ_LO: rd_mux = readback_q[31:0];
			tms_pkg::OFF_READ_HI: rd_mux = readback_q[63:32];
			tms_pkg::OFF_STATUS: rd_mux = {30'h0, status_q};
			tms_pkg::OFF_MASK: rd_mux = {30'h0, mask_q};
			tms_pkg::OFF_STATE: rd_mux = {30'h0, state_q};
			default: hit = 1'b0;
		endcase
	end

	// Read data sampled in setup so it comes from a flop in access
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
			slverr_q <= !hit;
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= tms_pkg::CTRL_RST;
			start_q <= tms_pkg::TIME_RST;
			period_q <= tms_pkg::PERIOD_RST;
			mask_q <= tms_pkg::IRQ_RST;
		end else if (wr_en) begin
			case (apb_req.paddr)
				tms_pkg::OFF_CTRL: ctrl_q <= apb_req.pwdata[1:0];
				tms_pkg::OFF_START_LO: start_q[31:0] <= apb_req.pwdata;
				tms_pkg::OFF_START_HI: start_q[63:32] <= apb_req.pwdata;
				tms_pkg::OFF_PERIOD: period_q <= apb_req.pwdata;
				tms_pkg::OFF_MASK: mask_q <= apb_req.pwdata[1:0];
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// ==========================================================
	// Local microsecond counter
	assign us_tick = div_q == tms_pkg::US_LAST;
	assign local_next = local_q + {63'h0, us_tick};

	always_ff @(posedge clk) begin
		if (srst || zero_cmd) begin
			div_q <= 5'h00;
			local_q <= tms_pkg::TIME_RST;
		end else begin
			div_q <= us_tick ? 5'h00 : div_q + 5'h01;
			local_q <= local_next;
		end
	end

	// ==========================================================
	// Precision-time counter in 8 ns ticks
	// A clock period is not a whole number of ticks, so the residue is
	// carried and the counter steps by 6 or 7 per clock.
	assign ns_sum = {4'h0, rem_q} + tms_pkg::CLK_NS_W;
	assign ptp_step = 4'(ns_sum / tms_pkg::PTP_NS_W);
	assign ptp_next = ptp_q + {60'h0, ptp_step};

	always_ff @(posedge clk) begin
		if (srst || (zero_cmd && !ptp_sel)) begin
			rem_q <= 3'h0;
			ptp_q <= tms_pkg::TIME_RST;
		end else begin
			rem_q <= 3'(ns_sum % tms_pkg::PTP_NS_W);
			ptp_q <= ptp_next;
		end
	end

	// ==========================================================
	// Modulo phase of the selected counter
	// Phase runs from the last boundary, so a new period takes effect
	// from the previous acquisition. Period must exceed 6 in PTP mode.
	assign sel_next = ptp_sel ? ptp_next : local_next;
	assign sel_step = ptp_sel ? {28'h0, ptp_step} : {31'h0, us_tick};
	assign phase_sum = {1'b0, phase_q} + {1'b0, sel_step};
	assign boundary = period_q != 32'h0000_0000 &&
		phase_sum >= {1'b0, period_q};
	assign phase_clr = zero_cmd && !ptp_sel;

	always_ff @(posedge clk) begin
		if (srst || phase_clr) begin
			phase_q <= 32'h0000_0000;
		end else if (boundary) begin
			phase_q <= 32'(phase_sum - {1'b0, period_q});
		end else begin
			phase_q <= phase_sum[31:0];
		end
	end

	// ==========================================================
	// Scheduler
	// Start is compared with the counter live; a start just before a
	// boundary may miss it by the write latency.
	assign first_ev = state_q == tms_pkg::SCH_PENDING && run && boundary &&
		!phase_clr && sel_next > start_q;
	assign ev = !phase_clr && boundary && ((state_q ==
		tms_pkg::SCH_RUNNING && run) || first_ev);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= tms_pkg::SCH_IDLE;
		end else begin
			case (state_q)
				tms_pkg::SCH_IDLE: begin
					if (run) begin
						state_q <= tms_pkg::SCH_PENDING;
					end
				end
				tms_pkg::SCH_PENDING: begin
					if (!run) begin
						state_q <= tms_pkg::SCH_IDLE;
					end else if (first_ev) begin
						state_q <= tms_pkg::SCH_RUNNING;
					end
				end
				tms_pkg::SCH_RUNNING: begin
					if (!run) begin
						state_q <= tms_pkg::SCH_IDLE;
					end
				end
				default: state_q <= tms_pkg::SCH_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			first_q <= tms_pkg::TIME_RST;
		end else if (first_ev) begin
			first_q <= sel_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= ev;
		end
	end
	assign acq_trigger = trig_q;

	// Capture of the selected counter
	always_ff @(posedge clk) begin
		if (srst) begin
			readback_q <= tms_pkg::TIME_RST;
		end else if (capture_cmd) begin
			readback_q <= ptp_sel ? ptp_q : local_q;
		end
	end

	// ==========================================================
	// Interrupts; a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (srst) begin
			status_q <= tms_pkg::IRQ_RST;
		end else begin
			status_q <= (status_q & ~((wr_en && apb_req.paddr ==
				tms_pkg::OFF_STATUS) ? apb_req.pwdata[1:0] : 2'h0)) |
				{first_ev, ev};
		end
	end
	assign irq = |(status_q & mask_q);

	// ==========================================================
	// Checks
	sequence s_first;
		first_ev ##0 ev;
	endsequence

	sequence s_zero_ptp;
		zero_cmd && ptp_sel;
	endsequence

	AST_US_STEP: assert property (@(posedge clk) disable iff (srst)
		(us_tick && !zero_cmd) |=> local_q == $past(local_q) + 64'h1)
		else $error("local counter missed its microsecond step");

	AST_US_HOLD: assert property (@(posedge clk) disable iff (srst)
		(!us_tick && !zero_cmd) |=> local_q == $past(local_q))
		else $error("local counter moved between ticks");

	AST_PTP_STEP: assert property (@(posedge clk) disable iff (srst)
		(!phase_clr && !srst) |=> (ptp_q - $past(ptp_q) == 64'h6 ||
		ptp_q - $past(ptp_q) == 64'h7))
		else $error("precision counter step is not 50 ns");

	AST_ZERO_BOTH: assert property (@(posedge clk) disable iff (srst)
		(zero_cmd && !ptp_sel) |=> local_q == 64'h0 && ptp_q == 64'h0)
		else $error("zero command did not clear both counters");

	AST_ZERO_LOCAL: assert property (@(posedge clk) disable iff (srst)
		s_zero_ptp |=> local_q == 64'h0 && ptp_q != 64'h0)
		else $error("zero command in precision mode cleared wrong counter");

	AST_FIRST_AFTER_START: assert property (@(posedge clk)
		disable iff (srst) (state_q == tms_pkg::SCH_PENDING && run &&
		boundary && !phase_clr && sel_next > start_q) |=> acq_trigger &&
		state_q == tms_pkg::SCH_RUNNING)
		else $error("first boundary after start time did not fire");

	AST_FIRST_RECORD: assert property (@(posedge clk) disable iff (srst)
		s_first |=> first_q == $past(sel_next) &&
		state_q == tms_pkg::SCH_RUNNING && acq_trigger)
		else $error("first event time not recorded");

	AST_REPEAT: assert property (@(posedge clk) disable iff (srst)
		(state_q == tms_pkg::SCH_RUNNING && run && boundary && !phase_clr)
		|=> acq_trigger)
		else $error("running boundary did not trigger");

	AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (srst)
		state_q == tms_pkg::SCH_IDLE |=> !acq_trigger)
		else $error("trigger while idle");

	AST_RESTART: assert property (@(posedge clk) disable iff (srst)
		phase_clr |=> phase_q == 32'h0 && !acq_trigger)
		else $error("phase not restarted with counter");

	AST_CAPTURE: assert property (@(posedge clk) disable iff (srst)
		(capture_cmd && !ptp_sel) |=> readback_q == $past(local_q))
		else $error("capture did not latch counter");

endmodule : tms_scheduler
